// File: status_byte_defines.vh
`ifndef STATUS_BYTE_DEFINES_VH
`define STATUS_BYTE_DEFINES_VH

// ****************************************************
// status word bit positions
// ****************************************************
`define BIT_ERROR     0
`define BIT_STOP      1
`define BIT_START     2
`define BIT_FAULT     3
`define BIT_ZERO      4
`define BIT_SWEEP     5
`define BIT_SERVICE   6
`define BIT_BUSY      7

// ****************************************************
// reset values and event width
// ****************************************************
`define STATUS_RESET  8'h00
`define MASK_RESET    4'h0
`define EVENT_WIDTH   4

`endif

// File: rise_detect.v
`timescale 1ns/100ps
`include "status_byte_defines.vh"

// two-flop synchroniser then rising edge on each event line
module rise_detect (
  input  wire                    clock_i,
  input  wire                    reset_i,
  input  wire [`EVENT_WIDTH-1:0] level_i,
  output reg  [`EVENT_WIDTH-1:0] rise_o
);

  reg [`EVENT_WIDTH-1:0] meta;
  reg [`EVENT_WIDTH-1:0] sync;
  reg [`EVENT_WIDTH-1:0] last;

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      meta   <= 4'h0;
      sync   <= 4'h0;
      last   <= 4'h0;
      rise_o <= 4'h0;
    end else begin
      meta   <= level_i;
      sync   <= meta;
      last   <= sync;
      rise_o <= sync & ~last;
    end
  end

endmodule

// File: level_sync.v
`timescale 1ns/100ps

// two-flop synchroniser for a live level
module level_sync (
  input  wire clock_i,
  input  wire reset_i,
  input  wire level_i,
  output reg  level_o
);

  reg meta;

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      meta    <= 1'b0;
      level_o <= 1'b0;
    end else begin
      meta    <= level_i;
      level_o <= meta;
    end
  end

endmodule

// File: status_byte_service_request.v
`timescale 1ns/100ps
`include "status_byte_defines.vh"

module status_byte_service_request (
  input  wire       CLOCK_I,
  input  wire       RESET_I,
  input  wire       ENTRY_FAULT_I,
  input  wire       SWEEP_STOP_I,
  input  wire       SWEEP_START_I,
  input  wire       HW_FAULT_I,
  input  wire       SWEEP_ACTIVE_I,
  input  wire       CMD_BUSY_I,
  input  wire       SERIAL_POLL_I,
  input  wire       STATUS_QUERY_COMMAND_I,
  input  wire       DEVICE_CLEAR_I,
  input  wire       SOFT_RESET_I,
  input  wire       PANEL_PRESET_I,
  input  wire       MASK_SET_COMMAND_I,
  input  wire [3:0] MASK_VALUE_I,
  output reg  [7:0] POLL_DATA_O,
  output reg        POLL_VALID_O,
  output reg  [7:0] STATUS_WORD_O,
  output reg  [3:0] MASK_O,
  output reg        SERVICE_REQUEST_O
);

  // ****************************************************
  // input synchronisation
  // ****************************************************
  wire [3:0] rise;
  wire       sweep_level;
  wire       busy_level;
  wire [7:0] cmd_rise;

  rise_detect event_edges (
    .clock_i (CLOCK_I),
    .reset_i (RESET_I),
    .level_i ({HW_FAULT_I, SWEEP_START_I, SWEEP_STOP_I, ENTRY_FAULT_I}),
    .rise_o  (rise)
  );

  rise_detect commands_a (
    .clock_i (CLOCK_I),
    .reset_i (RESET_I),
    .level_i ({SOFT_RESET_I, DEVICE_CLEAR_I, STATUS_QUERY_COMMAND_I, SERIAL_POLL_I}),
    .rise_o  (cmd_rise[3:0])
  );

  rise_detect commands_b (
    .clock_i (CLOCK_I),
    .reset_i (RESET_I),
    .level_i ({3'b000, PANEL_PRESET_I}),
    .rise_o  (cmd_rise[7:4])
  );

  level_sync sweep_sync (
    .clock_i (CLOCK_I),
    .reset_i (RESET_I),
    .level_i (SWEEP_ACTIVE_I),
    .level_o (sweep_level)
  );

  level_sync busy_sync (
    .clock_i (CLOCK_I),
    .reset_i (RESET_I),
    .level_i (CMD_BUSY_I),
    .level_o (busy_level)
  );

  // mask strobe and value cross from the command logic
  reg       mask_meta;
  reg       mask_sync;
  reg       mask_last;
  reg [3:0] mask_val_meta;
  reg [3:0] mask_val_sync;

  always @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mask_meta     <= 1'b0;
      mask_sync     <= 1'b0;
      mask_last     <= 1'b0;
      mask_val_meta <= `MASK_RESET;
      mask_val_sync <= `MASK_RESET;
    end else begin
      mask_meta     <= MASK_SET_COMMAND_I;
      mask_sync     <= mask_meta;
      mask_last     <= mask_sync;
      mask_val_meta <= MASK_VALUE_I;
      mask_val_sync <= mask_val_meta;
    end
  end

  wire poll_read = cmd_rise[0];
  wire query     = cmd_rise[1];
  wire dev_clear = cmd_rise[2];
  wire soft_rst  = cmd_rise[3];
  wire preset    = cmd_rise[4];
  wire mask_load = mask_sync & ~mask_last;

  // ****************************************************
  // event latches
  // ****************************************************
  reg  [3:0] events;
  reg        service;
  reg  [3:0] next_events;
  reg        next_service;
  wire       read_clear = poll_read | query;

  always @* begin
    next_events = events;
    // clears first so a same-cycle set wins
    if (read_clear) begin
      next_events = 4'h0;
    end
    if (rise[`BIT_START]) begin
      next_events[`BIT_STOP] = 1'b0;
    end
    if (rise[`BIT_STOP]) begin
      next_events[`BIT_START] = 1'b0;
    end
    next_events = next_events | rise;
  end

  always @* begin
    next_service = service;
    if (read_clear | dev_clear | soft_rst | preset) begin
      next_service = 1'b0;
    end
    // only a fresh event on any line, while some latched event is under an enabling mask, raises service
    if (|rise && |(next_events & MASK_O)) begin
      next_service = 1'b1;
    end
  end

  // one packing for the live word and the poll snapshot, so they never drift apart
  function [7:0] pack_word;
    input       busy;
    input       req;
    input       sweep;
    input [3:0] ev;
    begin
      pack_word = {busy, req, sweep, 1'b0, ev};
    end
  endfunction

  always @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      events            <= `MASK_RESET;
      service           <= 1'b0;
      MASK_O            <= `MASK_RESET;
      STATUS_WORD_O     <= `STATUS_RESET;
      POLL_DATA_O       <= `STATUS_RESET;
      POLL_VALID_O      <= 1'b0;
      SERVICE_REQUEST_O <= 1'b0;
    end else begin
      events  <= next_events;
      service <= next_service;
      if (mask_load) begin
        MASK_O <= mask_val_sync;
      end
      STATUS_WORD_O <= pack_word(busy_level, service, sweep_level, events);
      SERVICE_REQUEST_O <= next_service;
      POLL_VALID_O <= read_clear;
      if (read_clear) begin
        // snapshot before the clear takes effect
        POLL_DATA_O <= pack_word(busy_level, service, sweep_level, events);
      end
    end
  end

endmodule

// File: sbsr_sva.sv
`timescale 1ns/100ps
// ****
// checker
// ****
module sbsr_sva (
  input wire       CLOCK_I,
  input wire       RESET_I,
  input wire       SERIAL_POLL_I,
  input wire       SWEEP_ACTIVE_I,
  input wire       CMD_BUSY_I,
  input wire       POLL_VALID_O,
  input wire       SERVICE_REQUEST_O,
  input wire [7:0] STATUS_WORD_O,
  input wire [3:0] MASK_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  sequence poll_ans;
    ##[3:5] POLL_VALID_O ##1 !POLL_VALID_O;
  endsequence
  bit4_zero_a: assert property (!STATUS_WORD_O[4]) else $error("bit4 set");
  poll_answer_a: assert property ($rose(SERIAL_POLL_I) |-> poll_ans) else $error("poll");
  poll_drops_a: assert property (POLL_VALID_O |-> ##[0:1] !SERVICE_REQUEST_O) else $error("srq");
  srq_bit6_a: assert property ($rose(SERVICE_REQUEST_O) |-> ##[0:1] STATUS_WORD_O[6])
    else $error("bit6");
  srq_masked_a: assert property ($rose(SERVICE_REQUEST_O) |-> ##[0:1]
    ((STATUS_WORD_O[3:0] & MASK_O) != 4'h0)) else $error("mask");
  sweep_level_a: assert property ($rose(SWEEP_ACTIVE_I) |-> ##[2:5] STATUS_WORD_O[5])
    else $error("bit5");
  busy_level_a: assert property ($rose(CMD_BUSY_I) |-> ##[2:5] STATUS_WORD_O[7])
    else $error("bit7");
  poll_clear_a: assert property (POLL_VALID_O |=> !STATUS_WORD_O[6]) else $error("clr");
endmodule
bind status_byte_service_request sbsr_sva u_sva (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
  .SERIAL_POLL_I(SERIAL_POLL_I), .SWEEP_ACTIVE_I(SWEEP_ACTIVE_I), .CMD_BUSY_I(CMD_BUSY_I),
  .POLL_VALID_O(POLL_VALID_O), .SERVICE_REQUEST_O(SERVICE_REQUEST_O),
  .STATUS_WORD_O(STATUS_WORD_O), .MASK_O(MASK_O));

// File: poll_host.sv
`timescale 1ns/100ps
// ****
// host
// ****
module poll_host (
  input  wire       clock_i,
  input  wire       go_i,
  input  wire       valid_i,
  input  wire [7:0] data_i,
  output reg        poll_o,
  output reg        done_o,
  output reg  [7:0] got_o
);
  initial begin
    poll_o = 0;
    done_o = 0;
    got_o = 0;
  end
  always @(posedge clock_i) begin
    if (valid_i && poll_o) begin
      got_o <= data_i;
      done_o <= 1;
    end else if (!go_i) begin
      done_o <= 0;
    end
  end
  // poll held until answer sampled, so no retrigger
  always @(negedge clock_i) poll_o <= go_i & !done_o;
endmodule

// File: status_byte_service_request_tb.sv
`timescale 1ns/100ps
module status_byte_service_request_tb;
  reg clk = 0, rst = 1, go = 0;
  reg [10:0] in = 0;
  reg [3:0] mv = 0;
  wire [7:0] pd, sw, got;
  wire pv, srq, poll, done;
  wire [3:0] mk;
  integer errors = 0, n_compared = 0, i, k;
  reg [7:0] r, e;
  reg [7:0] rows [0:5];
  initial forever #4 clk = ~clk;
  status_byte_service_request u_dut (.CLOCK_I(clk), .RESET_I(rst), .ENTRY_FAULT_I(in[0]),
    .SWEEP_STOP_I(in[1]), .SWEEP_START_I(in[2]), .HW_FAULT_I(in[3]), .SWEEP_ACTIVE_I(in[8]),
    .CMD_BUSY_I(in[9]), .SERIAL_POLL_I(poll), .STATUS_QUERY_COMMAND_I(in[4]),
    .DEVICE_CLEAR_I(in[5]), .SOFT_RESET_I(in[6]), .PANEL_PRESET_I(in[7]),
    .MASK_SET_COMMAND_I(in[10]), .MASK_VALUE_I(mv), .POLL_DATA_O(pd), .POLL_VALID_O(pv),
    .STATUS_WORD_O(sw), .MASK_O(mk), .SERVICE_REQUEST_O(srq));
  poll_host u_host (.clock_i(clk), .go_i(go), .valid_i(pv), .data_i(pd), .poll_o(poll),
    .done_o(done), .got_o(got));
  task chk(input string nm, input [7:0] x, input [7:0] s);
    begin
      n_compared = n_compared + 1;
      if (x !== s) begin
        errors = errors + 1;
        $display("[FAIL] %0s exp %h seen %h", nm, x, s);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task pulse(input integer b);
    begin
      in[b] = 1;
      wt(4);
      in[b] = 0;
      wt(8);
    end
  endtask
  task setmask(input [3:0] m);
    begin
      mv = m;
      wt(2);
      pulse(10);
    end
  endtask
  task dopoll;
    begin
      go = 1;
      for (k = 0; k < 20 && done !== 1'b1; k = k + 1) wt(1);
      if (done !== 1'b1) begin
        errors = errors + 1;
        wrap_up;
      end
      go = 0;
      wt(8);
    end
  endtask
  initial begin
    rows[0] = 8'h18; rows[1] = 8'h29; rows[2] = 8'h4a;
    rows[3] = 8'h8b; rows[4] = 8'h20; rows[5] = 8'h73;
    wt(16);
    chk("rst", 8'h00, {sw[7:1], srq});
    rst = 0;
    wt(2);
    for (i = 0; i < 6; i = i + 1) begin
      r = rows[i];
      setmask(r[7:4]);
      pulse(r[1:0]);
      e = (8'h01 << r[1:0]) | {1'b0, r[3], 6'h00};
      chk("word", e, sw);
      chk("srq", {7'h00, r[3]}, {7'h00, srq});
      dopoll;
      chk("poll", e, got);
      chk("clr", 8'h00, {sw[7:1], srq});
      $display("row %0d done", i);
    end
    setmask(4'h0);
    pulse(0);
    setmask(4'h1);
    chk("unmask", 8'h01, sw);
    chk("unmask srq", 8'h00, {7'h00, srq});
    in[0] = 1;
    wt(8);
    dopoll;
    wt(8);
    chk("hold", 8'h00, sw);
    in[0] = 0;
    in[9:8] = 2'b11;
    setmask(4'hf);
    chk("level", 8'ha0, sw);
    chk("level srq", 8'h00, {7'h00, srq});
    chk("mask", 8'h0f, {4'h0, mk});
    in[9:8] = 2'b00;
    for (i = 4; i < 8; i = i + 1) begin
      pulse(3);
      pulse(i);
      chk("clear", (i == 4) ? 8'h00 : 8'h08, {sw[7:1], srq});
      dopoll;
    end
    pulse(2);
    pulse(1);
    chk("stop", 8'h42, sw);
    dopoll;
    $display("hand tests done");
    wrap_up;
  end
endmodule
